// ### bpmc_pkg.sv
`default_nettype none
package bpmc_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_WIN_BASE = 8'h00;
	localparam logic [7:0] OFF_WIN_LIMIT = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_PM_CTRL = 8'hE0;
	localparam logic [7:0] OFF_LAST_CAP = 8'hE4;

	// ----------------------------------------
	// power-management control word
	// ----------------------------------------
	localparam int PS_LSB = 0;
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D3 = 2'h3;
	localparam logic [1:0] PS_RST = 2'h0;

	// ----------------------------------------
	// last capability entry
	// ----------------------------------------
	localparam int CAP_ID_LSB = 0;
	localparam int CAP_NEXT_LSB = 8;
	localparam logic [7:0] CAP_ID_PM = 8'h01;
	localparam logic [7:0] CAP_NEXT_END = 8'h00;

	// ----------------------------------------
	// status word fields
	// ----------------------------------------
	localparam int ST_PEND_VALID_LSB = 0;
	localparam int ST_PEND_DONE_LSB = 2;
	localparam int ST_OUT0_LSB = 4;
	localparam int ST_OUT1_LSB = 6;
	localparam int ST_PS_LSB = 8;
	localparam int ST_FIFO_FULL_LSB = 10;

	// ----------------------------------------
	// reset values and misc
	// ----------------------------------------
	localparam logic [31:0] WIN_BASE_RST = 32'h0000_0000;
	localparam logic [31:0] WIN_LIMIT_RST = 32'h0000_0000;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0]
	{
		OUT_NONE = 2'h0,
		OUT_POSTED = 2'h1,
		OUT_RETRY = 2'h2,
		OUT_DONE = 2'h3
	} bpmc_outcome_t;

	typedef struct packed
	{
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [3:0] be;
	} bpmc_cycle_t;

	typedef struct packed
	{
		logic upstream;
		bpmc_cycle_t cyc;
		logic [31:0] data;
	} bpmc_post_t;

	typedef struct packed
	{
		logic frame_n;
		logic device_select_n;
		logic [31:0] ad;
		logic [3:0] cbe;
	} bpmc_pin_in_t;

	typedef struct packed
	{
		logic device_select_n;
		logic trdy_n;
		logic stop_n;
	} bpmc_tgt_t;

endpackage
`default_nettype wire

// ### bpmc_bridge.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// posted-write fifo
// ----------------------------------------
module bpmc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// flags from the count
	assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rd_q];

	// storage
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// pointers and registered flags
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else if (flush)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(pop);
			cnt_q <= cnt_d;
			in_ready <= cnt_d != (AW+1)'(DEPTH);
			out_valid <= cnt_d != '0;
		end
	end
endmodule

// ----------------------------------------
// bridge power management and claim logic
// ----------------------------------------
module bpmc_bridge (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire bpmc_pkg::bpmc_pin_in_t primary_pins_i,
	input wire bpmc_pkg::bpmc_pin_in_t secondary_pins_i,
	output bpmc_pkg::bpmc_tgt_t primary_tgt_o,
	output logic primary_tgt_oe_o,
	output bpmc_pkg::bpmc_tgt_t secondary_tgt_o,
	output logic secondary_tgt_oe_o,
	output logic fwd_valid_o,
	output bpmc_pkg::bpmc_post_t fwd_data_o,
	input wire logic fwd_ready_i,
	output logic [1:0] delayed_valid_o,
	output bpmc_pkg::bpmc_cycle_t [1:0] delayed_cyc_o,
	input wire logic [1:0] delayed_done_i,
	output logic internal_reset_o
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic in_window(input logic [31:0] a, input logic [31:0] b, input logic [31:0] l);
		in_window = (a >= b) && (a <= l);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int k = 0; k < 4; k++)
			merge[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
	endfunction

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_n;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [1:0] ps_q;
	logic [31:0] win_base_q;
	logic [31:0] win_limit_q;
	logic soft_q;
	logic [1:0] pend_valid;
	logic [1:0] pend_done;
	bpmc_pkg::bpmc_outcome_t [1:0] last_out;
	logic fifo_in_ready;

	// bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr = wb_req & wb_we_i;
	wire sel_pm = wb_adr_i == bpmc_pkg::OFF_PM_CTRL;
	wire sel_base = wb_adr_i == bpmc_pkg::OFF_WIN_BASE;
	wire sel_limit = wb_adr_i == bpmc_pkg::OFF_WIN_LIMIT;
	wire [1:0] ps_wdata = wb_dat_i[bpmc_pkg::PS_LSB +: 2];
	wire ps_legal = (ps_wdata == bpmc_pkg::PS_D0) | (ps_wdata == bpmc_pkg::PS_D3);
	wire ps_write = wb_wr & sel_pm & wb_sel_i[0] & ps_legal;
	wire wake = ps_write & (ps_wdata == bpmc_pkg::PS_D0) & (ps_q == bpmc_pkg::PS_D3);

	// read mux; unlisted bits read zero
	logic [31:0] rdata;
	always_comb
	begin
		rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			bpmc_pkg::OFF_PM_CTRL: rdata[bpmc_pkg::PS_LSB +: 2] = ps_q;
			bpmc_pkg::OFF_LAST_CAP:
			begin
				rdata[bpmc_pkg::CAP_ID_LSB +: 8] = bpmc_pkg::CAP_ID_PM;
				rdata[bpmc_pkg::CAP_NEXT_LSB +: 8] = bpmc_pkg::CAP_NEXT_END;
			end
			bpmc_pkg::OFF_WIN_BASE: rdata = win_base_q;
			bpmc_pkg::OFF_WIN_LIMIT: rdata = win_limit_q;
			bpmc_pkg::OFF_STATUS:
			begin
				rdata[bpmc_pkg::ST_PEND_VALID_LSB +: 2] = pend_valid;
				rdata[bpmc_pkg::ST_PEND_DONE_LSB +: 2] = pend_done;
				rdata[bpmc_pkg::ST_OUT0_LSB +: 2] = last_out[0];
				rdata[bpmc_pkg::ST_OUT1_LSB +: 2] = last_out[1];
				rdata[bpmc_pkg::ST_PS_LSB +: 2] = ps_q;
				rdata[bpmc_pkg::ST_FIFO_FULL_LSB] = ~fifo_in_ready;
			end
			default: rdata = 32'h0000_0000;
		endcase
	end

	// bus answer, one wait state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rdata : wb_dat_o;
		end
	end

	// power state and windows
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ps_q <= bpmc_pkg::PS_RST;
			win_base_q <= bpmc_pkg::WIN_BASE_RST;
			win_limit_q <= bpmc_pkg::WIN_LIMIT_RST;
			soft_q <= 1'b0;
			internal_reset_o <= 1'b0;
		end
		else
		begin
			soft_q <= wake;
			internal_reset_o <= wake;
			if (ps_write)
				ps_q <= ps_wdata;
			if (soft_q)
			begin
				win_base_q <= bpmc_pkg::WIN_BASE_RST;
				win_limit_q <= bpmc_pkg::WIN_LIMIT_RST;
			end
			else
			begin
				if (wb_wr & sel_base)
					win_base_q <= merge(win_base_q, wb_dat_i, wb_sel_i);
				if (wb_wr & sel_limit)
					win_limit_q <= merge(win_limit_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ----------------------------------------
	// per-port claim engines
	// ----------------------------------------
	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_DECODE = 4'h2,
		ST_RESP = 4'h4,
		ST_WAIT = 4'h8
	} bpmc_state_t;

	bpmc_pkg::bpmc_pin_in_t pins [2];
	bpmc_pkg::bpmc_tgt_t tgt [2];
	logic [1:0] tgt_oe;
	logic [1:0] push;
	bpmc_pkg::bpmc_post_t post [2];
	wire in_d0 = ps_q == bpmc_pkg::PS_D0;

	assign pins[0] = primary_pins_i;
	assign pins[1] = secondary_pins_i;

	for (genvar i = 0; i < 2; i++)
	begin : g_port
		bpmc_pkg::bpmc_pin_in_t s1_q;
		bpmc_pkg::bpmc_pin_in_t s2_q;
		bpmc_pkg::bpmc_pin_in_t s3_q;
		logic frame_f_q;
		logic devsel_f_q;
		bpmc_state_t st_q;
		bpmc_pkg::bpmc_cycle_t cur_q;
		bpmc_pkg::bpmc_cycle_t pend_q;
		logic pv_q;
		logic pd_q;
		logic complete_q;
		bpmc_pkg::bpmc_outcome_t out_q;

		// filtered frame and device-select
		wire frame_nxt = (s2_q.frame_n == s3_q.frame_n) ? s3_q.frame_n : frame_f_q;
		wire devsel_nxt = (s2_q.device_select_n == s3_q.device_select_n) ? s3_q.device_select_n : devsel_f_q;
		wire start = frame_f_q & ~frame_nxt;

		// claim decision in decode
		bpmc_pkg::bpmc_cycle_t seen;
		assign seen = '{cmd: cur_q.cmd, addr: cur_q.addr, be: s3_q.cbe};
		wire hit = in_window(cur_q.addr, win_base_q, win_limit_q);
		wire other_claim = (i == 0) & ~devsel_nxt;
		wire toward = (i == 0) ? hit : ~hit;
		wire claim = (st_q == ST_DECODE) & in_d0 & toward & ~other_claim;
		wire match = pv_q & (pend_q == seen);
		logic yield_post;
		// secondary yields posting to primary; primary never yields
		if (i == 0)
		begin : g_first
			assign yield_post = 1'b0;
		end
		else
		begin : g_later
			assign yield_post = push[0];
		end
		wire can_post = (cur_q.cmd == bpmc_pkg::CMD_MEM_WRITE) & fifo_in_ready & ~yield_post;
		wire finish = claim & match & pd_q;
		wire do_post = claim & ~pv_q & can_post;
		wire do_defer = claim & ~pv_q & ~can_post;

		assign push[i] = do_post;
		assign post[i] = '{upstream: (i == 1), cyc: seen, data: s3_q.ad};
		assign pend_valid[i] = pv_q;
		assign pend_done[i] = pd_q;
		assign last_out[i] = out_q;
		assign delayed_cyc_o[i] = pend_q;
		assign delayed_valid_o[i] = pv_q;

		// pin samplers
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				s1_q <= '{frame_n: 1'b1, device_select_n: 1'b1, default: '0};
				s2_q <= '{frame_n: 1'b1, device_select_n: 1'b1, default: '0};
				s3_q <= '{frame_n: 1'b1, device_select_n: 1'b1, default: '0};
				frame_f_q <= 1'b1;
				devsel_f_q <= 1'b1;
			end
			else
			begin
				s1_q <= pins[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				frame_f_q <= frame_nxt;
				devsel_f_q <= devsel_nxt;
			end
		end

		// cycle state machine
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				st_q <= ST_IDLE;
				cur_q <= '0;
				complete_q <= 1'b0;
				out_q <= bpmc_pkg::OUT_NONE;
			end
			else if (soft_q)
			begin
				st_q <= ST_IDLE;
				complete_q <= 1'b0;
				out_q <= bpmc_pkg::OUT_NONE;
			end
			else
			begin
				unique case (st_q)
					ST_IDLE:
					begin
						if (start)
						begin
							st_q <= ST_DECODE;
							cur_q <= '{cmd: s3_q.cbe, addr: s3_q.ad, be: 4'h0};
						end
					end
					ST_DECODE:
					begin
						st_q <= claim ? ST_RESP : ST_WAIT;
						complete_q <= finish | do_post;
						if (finish)
							out_q <= bpmc_pkg::OUT_DONE;
						else if (do_post)
							out_q <= bpmc_pkg::OUT_POSTED;
						else if (claim)
							out_q <= bpmc_pkg::OUT_RETRY;
					end
					ST_RESP, ST_WAIT:
					begin
						if (frame_nxt)
							st_q <= ST_IDLE;
					end
				endcase
			end
		end

		// target signals, held until frame is released
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				tgt[i] <= '{device_select_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1};
				tgt_oe[i] <= 1'b0;
			end
			else
			begin
				tgt_oe[i] <= (claim | (st_q == ST_RESP)) & ~soft_q & ~((st_q == ST_RESP) & frame_nxt);
				tgt[i].device_select_n <= ~((claim | (st_q == ST_RESP)) & ~frame_nxt);
				tgt[i].trdy_n <= ~(claim ? (finish | do_post) : ((st_q == ST_RESP) & complete_q & ~frame_nxt));
				tgt[i].stop_n <= ~(claim ? ~(finish | do_post) : ((st_q == ST_RESP) & ~complete_q & ~frame_nxt));
			end
		end

		// delayed transaction store
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				pv_q <= 1'b0;
				pd_q <= 1'b0;
				pend_q <= '0;
			end
			else if (soft_q)
			begin
				pv_q <= 1'b0;
				pd_q <= 1'b0;
			end
			else if (do_defer)
			begin
				pv_q <= 1'b1;
				pd_q <= 1'b0;
				pend_q <= seen;
			end
			else if (finish)
			begin
				pv_q <= 1'b0;
				pd_q <= 1'b0;
			end
			else if (pv_q & delayed_done_i[i])
				pd_q <= 1'b1;
		end
	end

	assign primary_tgt_o = tgt[0];
	assign primary_tgt_oe_o = tgt_oe[0];
	assign secondary_tgt_o = tgt[1];
	assign secondary_tgt_oe_o = tgt_oe[1];

	// ----------------------------------------
	// posted writes toward the far port
	// ----------------------------------------
	bpmc_fifo #(
		.W($bits(bpmc_pkg::bpmc_post_t)),
		.DEPTH(bpmc_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.flush(soft_q),
		.in_valid(|push),
		.in_data(push[0] ? post[0] : post[1]),
		.in_ready(fifo_in_ready),
		.out_valid(fwd_valid_o),
		.out_data(fwd_data_o),
		.out_ready(fwd_ready_i)
	);
endmodule
`default_nettype wire

// ### bpmc_bridge_chk.sv
`timescale 1ns/1ns
`default_nettype none
module bpmc_bridge_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire bpmc_pkg::bpmc_pin_in_t primary_pins_i,
	input wire bpmc_pkg::bpmc_pin_in_t secondary_pins_i,
	input wire bpmc_pkg::bpmc_tgt_t primary_tgt_o,
	input wire logic primary_tgt_oe_o,
	input wire bpmc_pkg::bpmc_tgt_t secondary_tgt_o,
	input wire logic secondary_tgt_oe_o,
	input wire logic internal_reset_o
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// read answers and d0 writes
	wire logic rd_pm = wb_ack_o && !wb_we_i && wb_adr_i == bpmc_pkg::OFF_PM_CTRL;
	wire logic rd_cap = wb_ack_o && !wb_we_i && wb_adr_i == bpmc_pkg::OFF_LAST_CAP;
	wire logic pm_d0_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == bpmc_pkg::OFF_PM_CTRL
		&& wb_dat_i[1:0] == bpmc_pkg::PS_D0;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_ps_code_legal: assert property (rd_pm |-> wb_dat_o[1:0] == 2'h0 || wb_dat_o[1:0] == 2'h3)
		else $error("power state reads an unimplemented code");
	a_pm_reserved_zero: assert property (rd_pm |-> wb_dat_o[15:2] == 14'h0000)
		else $error("read-only control bits not zero");
	a_cap_entry_fixed: assert property (rd_cap |-> wb_dat_o[15:0] == 16'h0001)
		else $error("capability entry wrong");
	a_prim_claim_frame: assert property ($rose(primary_tgt_oe_o) |->
		!primary_pins_i.frame_n && !$past(primary_pins_i.frame_n, 2))
		else $error("primary claim without frame");
	a_sec_claim_frame: assert property ($rose(secondary_tgt_oe_o) |->
		!secondary_pins_i.frame_n && !$past(secondary_pins_i.frame_n, 2))
		else $error("secondary claim without frame");
	a_prim_claim_shape: assert property (primary_tgt_oe_o |->
		!primary_tgt_o.device_select_n && primary_tgt_o.trdy_n != primary_tgt_o.stop_n)
		else $error("primary claim lines malformed");
	a_sec_claim_shape: assert property (secondary_tgt_oe_o |->
		!secondary_tgt_o.device_select_n && secondary_tgt_o.trdy_n != secondary_tgt_o.stop_n)
		else $error("secondary claim lines malformed");
	a_claim_release: assert property ((primary_pins_i.frame_n && secondary_pins_i.frame_n) [*6] |=>
		!primary_tgt_oe_o && !secondary_tgt_oe_o)
		else $error("target lines held after frame");
	a_soft_reset_cause: assert property (internal_reset_o |-> $past(pm_d0_wr, 1) || $past(pm_d0_wr, 2))
		else $error("internal reset without d0 write");
	a_soft_reset_pulse: assert property (internal_reset_o |=> !internal_reset_o)
		else $error("internal reset longer than a cycle");
	c_prim_posted: cover property (primary_tgt_oe_o && !primary_tgt_o.trdy_n);
	c_prim_retry: cover property (primary_tgt_oe_o && !primary_tgt_o.stop_n);
	c_soft_reset: cover property (internal_reset_o);
	c_sec_retry: cover property (secondary_tgt_oe_o && !secondary_tgt_o.stop_n);
endmodule
bind bpmc_bridge bpmc_bridge_chk bpmc_bridge_chk_inst (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .primary_pins_i, .secondary_pins_i, .primary_tgt_o,
	.primary_tgt_oe_o, .secondary_tgt_o, .secondary_tgt_oe_o, .internal_reset_o);
`default_nettype wire

// ### bpmc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module bpmc_far_model #(
	parameter int DONE_DLY = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic stall,
	input wire logic fwd_valid,
	input wire bpmc_pkg::bpmc_post_t fwd_data,
	output logic fwd_ready,
	input wire logic [1:0] delayed_valid,
	output logic [1:0] delayed_done,
	output bpmc_pkg::bpmc_post_t last_q,
	output int pops_q
);
	int cnt_q [2];
	// far port stalls on request
	assign fwd_ready = !stall;
	// take posted words, finish deferred cycles after a delay
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			last_q <= '0;
			pops_q <= 0;
			delayed_done <= 2'h0;
			cnt_q <= '{0, 0};
		end
		else
		begin
			if (fwd_valid && fwd_ready)
			begin
				last_q <= fwd_data;
				pops_q <= pops_q + 1;
			end
			for (int i = 0; i < 2; i++)
			begin
				delayed_done[i] <= delayed_valid[i] && cnt_q[i] == DONE_DLY;
				cnt_q[i] <= !delayed_valid[i] ? 0 : (cnt_q[i] > DONE_DLY ? cnt_q[i] : cnt_q[i] + 1);
			end
		end
	end
endmodule
`default_nettype wire

// ### bpmc_bridge_bench.sv
`timescale 1ns/1ns
`default_nettype none
module bpmc_bridge_bench;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, stall = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat, dout;
	logic fr [2] = '{1'b1, 1'b1};
	logic oth [2] = '{1'b1, 1'b1};
	logic [31:0] ad [2] = '{32'h0, 32'h0};
	logic [3:0] cb [2] = '{4'h0, 4'h0};
	bpmc_pkg::bpmc_tgt_t tg [2];
	logic oe [2];
	bpmc_pkg::bpmc_pin_in_t pin [2];
	logic ack, irst, fv, fr_rdy;
	bpmc_pkg::bpmc_post_t fwd, last;
	bpmc_pkg::bpmc_cycle_t [1:0] dcyc;
	logic [1:0] dv, dd, r;
	int pops, n_fail = 0, n_compared = 0, n_irst = 0;
	localparam logic [3:0] MW = bpmc_pkg::CMD_MEM_WRITE;
	localparam logic [7:0] PM = bpmc_pkg::OFF_PM_CTRL;
	always #2 clk = ~clk;
	// device select wire: bridge when enabled, else other target
	assign pin[0] = {fr[0], oe[0] ? tg[0].device_select_n : oth[0], ad[0], cb[0]};
	assign pin[1] = {fr[1], oe[1] ? tg[1].device_select_n : oth[1], ad[1], cb[1]};
	always @(posedge clk) if (irst === 1'b1) n_irst++;
	bpmc_bridge bpmc_bridge_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
		.primary_pins_i(pin[0]), .secondary_pins_i(pin[1]), .primary_tgt_o(tg[0]), .primary_tgt_oe_o(oe[0]),
		.secondary_tgt_o(tg[1]), .secondary_tgt_oe_o(oe[1]), .fwd_valid_o(fv), .fwd_data_o(fwd),
		.fwd_ready_i(fr_rdy), .delayed_valid_o(dv), .delayed_cyc_o(dcyc), .delayed_done_i(dd),
		.internal_reset_o(irst));
	bpmc_far_model bpmc_far_model_inst (.clk(clk), .resetn(resetn), .stall(stall), .fwd_valid(fv),
		.fwd_data(fwd), .fwd_ready(fr_rdy), .delayed_valid(dv), .delayed_done(dd), .last_q(last), .pops_q(pops));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dout;
		{cyc, stb, we} <= 3'h0;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat[15:0], e);
	endtask
	// one initiator cycle, single data phase, judged by the target lines
	task pci(input int p, input logic [31:0] a, input logic [3:0] c, input logic o, input logic [1:0] e);
		int n;
		@(posedge clk);
		{fr[p], ad[p], cb[p], oth[p]} <= {1'b0, a, c, o};
		@(posedge clk);
		{ad[p], cb[p]} <= {a ^ 32'hA5A5_0000, 4'h0};
		n = 0;
		do @(posedge clk); while (oe[p] !== 1'b1 && ++n < 12);
		r = oe[p] !== 1'b1 ? 2'h0 : tg[p].trdy_n === 1'b0 ? 2'h1 : tg[p].stop_n === 1'b0 ? 2'h2 : 2'h3;
		{fr[p], ad[p], oth[p]} <= {1'b1, ~ad[p], 1'b1};
		repeat (10) @(posedge clk);
		chk(r, e);
	endtask
	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(PM, 16'h0000);
		rd(bpmc_pkg::OFF_LAST_CAP, 16'h0001);
		rd(8'hFC, 16'h0000);
		wb(1'b1, bpmc_pkg::OFF_WIN_BASE, 32'h0000_1000);
		wb(1'b1, bpmc_pkg::OFF_WIN_LIMIT, 32'h0000_1FFF);
		pci(0, 32'h0000_1004, MW, 1'b1, 2'h1);
		repeat (4) @(posedge clk);
		chk(last.data, 32'hA5A5_1004);
		pci(0, 32'h0000_2000, MW, 1'b1, 2'h0);
		pci(0, 32'h0000_1000, MW, 1'b0, 2'h0);
		pci(0, 32'h0000_1800, 4'h6, 1'b1, 2'h2);
		chk({dcyc[0].cmd, dcyc[0].be, dcyc[0].addr[23:0]}, 32'h6000_1800);
		chk(dv, 2'h1);
		rd(bpmc_pkg::OFF_STATUS, 16'h0025);
		pci(0, 32'h0000_1804, 4'h6, 1'b1, 2'h2);
		pci(0, 32'h0000_1800, 4'h6, 1'b1, 2'h1);
		pci(1, 32'h0000_1004, MW, 1'b1, 2'h0);
		pci(1, 32'h0000_8000, MW, 1'b1, 2'h1);
		repeat (4) @(posedge clk);
		chk({last.upstream, last.cyc.addr[30:0]}, 32'h8000_8000);
		pci(1, 32'h0000_9000, 4'h6, 1'b1, 2'h2);
		pci(1, 32'h0000_9000, 4'h6, 1'b1, 2'h1);
		stall <= 1'b1;
		for (int i = 0; i < 16; i++) pci(0, 32'h0000_1100 + 4 * i, MW, 1'b1, 2'h1);
		pci(0, 32'h0000_1F00, MW, 1'b1, 2'h2);
		stall <= 1'b0;
		repeat (40) @(posedge clk);
		chk(pops, 18);
		pci(0, 32'h0000_1F00, MW, 1'b1, 2'h1);
		wb(1'b1, PM, 32'h0000_FFFF);
		rd(PM, 16'h0003);
		for (int i = 1; i < 3; i++)
		begin
			wb(1'b1, PM, i);
			rd(PM, 16'h0003);
		end
		pci(0, 32'h0000_1004, MW, 1'b1, 2'h0);
		chk(n_irst, 0);
		wb(1'b1, PM, 32'h0);
		repeat (3) @(posedge clk);
		chk(n_irst, 1);
		rd(PM, 16'h0000);
		rd(bpmc_pkg::OFF_WIN_BASE, 16'h0000);
		give_verdict;
	end
	initial
	begin
		#80000;
		n_fail++;
		give_verdict;
	end
endmodule
`default_nettype wire
